// ===== cdsp_consts.vh
`ifndef CDSP_CONSTS_VH
`define CDSP_CONSTS_VH
// -------------------------------------------------------------
// register indices (byte address = 4 * index)
// -------------------------------------------------------------
`define CDSP_IDX_REGCTL 14'h0812
`define CDSP_IDX_THROTTLE 14'h088c
`define CDSP_IDX_STATUS 14'h088d
`define CDSP_ADDR_W 16
// -------------------------------------------------------------
// throttle register fields
// -------------------------------------------------------------
`define CDSP_TH_IDLE 7
`define CDSP_TH_DOZE 6
`define CDSP_TH_ROI 5
`define CDSP_TH_DOE 4
`define CDSP_TH_RATIO_HI 2
`define CDSP_TH_RATIO_LO 0
`define CDSP_TH_RESET 8'h00
// -------------------------------------------------------------
// regulator control and status fields
// -------------------------------------------------------------
`define CDSP_RC_LPSEL 1
`define CDSP_RC_RESET 8'h00
`define CDSP_ST_TO_N 4
`define CDSP_ST_PD_N 3
// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define CDSP_CLK_MHZ 50
`define CDSP_OST_PERIODS 1024
`define CDSP_REG_STAB_NS 5000
`define CDSP_REG_STAB_CYC ((`CDSP_REG_STAB_NS*`CDSP_CLK_MHZ+999)/1000)
`endif

// ===== cdsp_power_ctrl.v
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "cdsp_consts.vh"
module cdsp_power_ctrl (
  input wire clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sleepExec,
  input wire irqEntry,
  input wire irqReturn,
  input wire enabledIrqPending,
  input wire globalIrqEnable,
  input wire wdtWake,
  input wire wdtSleepRun,
  input wire crystalMode,
  input wire flagsRestore,
  input wire lowVoltageStrap,
  output reg cpuClkEn,
  output reg pfmEn,
  output reg periphClkEn,
  output reg prefetchReq,
  output reg vectorAfterNext,
  output reg wdtClear,
  output reg wdtRunEn,
  output reg ioHold,
  output reg regLowPower,
  output reg sleepActive,
  output reg idleActive,
  output reg powerDownFlagN,
  output reg timeoutFlagN
);

  // -------------------------------------------------------------
  // states of the power sequencer
  // -------------------------------------------------------------
  localparam [2:0] ST_RUN = 3'h0; // normal or doze execution
  localparam [2:0] ST_IDLE = 3'h1; // cpu halted, peripherals run
  localparam [2:0] ST_SLEEP = 3'h2; // cpu clock gated
  localparam [2:0] ST_OST = 3'h3; // oscillator start-up wait
  localparam [2:0] ST_STAB = 3'h4; // regulator settle wait
  localparam [2:0] ST_RESUME = 3'h5; // one-cycle restart boundary

  // counts worked out at full width, then cut to the counter width
  localparam integer OST_LAST = `CDSP_OST_PERIODS - 1;
  localparam integer STAB_LAST = `CDSP_REG_STAB_CYC - 1;
  localparam [10:0] OST_TOP = OST_LAST[10:0];
  localparam [10:0] STAB_TOP = STAB_LAST[10:0];

  // -------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------
  // last count of a doze period: ratio 0 -> 1, ratio 7 -> 255
  function [7:0] dozeTop;
    input [2:0] ratio;
    reg [8:0] n;
    begin
      n = 9'h002 << ratio;
      dozeTop = n[7:0] - 8'h01;
    end
  endfunction

  // word address match on an aligned index
  function hit;
    input [15:0] addr;
    input [13:0] idx;
    begin
      hit = (addr[15:2] == idx) && (addr[1:0] == 2'h0);
    end
  endfunction

  // -------------------------------------------------------------
  // state declarations
  // -------------------------------------------------------------
  reg [2:0] state_r; // sequencer state
  reg [2:0] state_nxt;
  reg [10:0] waitCnt_r; // start-up and settle counter
  reg [10:0] waitCnt_nxt;
  reg [7:0] dozeCnt_r; // doze period counter
  reg [7:0] dozeCnt_nxt;
  reg idleSel_r; // idle_select_bit
  reg dozeAct_r; // doze_active_bit
  reg roi_r; // recover_on_irq_bit
  reg doe_r; // doze_on_exit_bit
  reg [2:0] ratio_r; // doze ratio field
  reg lpSel_r; // regulator_lowpower_select
  reg lpUsed_r; // low-power sleep taken this time
  reg lvSync1_r; // strap synchroniser, first stage
  reg lvSync2_r; // strap synchroniser, second stage
  reg lowVolt_r; // strap caught at reset
  wire apbSetup;
  wire apbWrite;
  wire dozeTick;
  wire wakeReq;
  wire [7:0] thRead;

  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pready & pwrite;
  assign dozeTick = (dozeCnt_r == 8'h00);
  // individual enable already folded into the pending level
  assign wakeReq = enabledIrqPending | wdtWake;
  assign thRead = {idleSel_r, dozeAct_r, roi_r, doe_r, 1'b0, ratio_r};

  // -------------------------------------------------------------
  // low-voltage strap capture
  // -------------------------------------------------------------
  // strap is a pin, so two flops before it is looked at
  always @(posedge clk) begin
    lvSync1_r <= lowVoltageStrap;
    lvSync2_r <= lvSync1_r;
  end

  // caught while reset is held, frozen afterwards
  always @(posedge clk) begin
    if (!rst_b) begin
      lowVolt_r <= lvSync2_r;
    end
  end

  // -------------------------------------------------------------
  // apb slave, zero wait states
  // -------------------------------------------------------------
  // answer prepared in the setup cycle so pready is a flop
  always @(posedge clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (apbSetup) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (hit(paddr, `CDSP_IDX_THROTTLE)) begin
        prdata <= {24'h000000, thRead};
      end else if (hit(paddr, `CDSP_IDX_REGCTL)) begin
        // low-voltage parts have no selectable option
        prdata <= {30'h00000000, lpSel_r & ~lowVolt_r, 1'b0};
      end else if (hit(paddr, `CDSP_IDX_STATUS)) begin
        prdata <= {27'h0000000, timeoutFlagN, powerDownFlagN,
                   state_r};
      end else begin
        // unmapped: error, data reads zero
        pslverr <= 1'b1;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // throttle and regulator registers
  // -------------------------------------------------------------
  // hardware events win over a software write in the same cycle;
  // the cpu cannot return and store in one instruction anyway
  always @(posedge clk) begin
    if (!rst_b) begin
      idleSel_r <= 1'b0;
      dozeAct_r <= 1'b0;
      roi_r <= 1'b0;
      doe_r <= 1'b0;
      ratio_r <= 3'h0;
      lpSel_r <= 1'b0;
    end else begin
      if (apbWrite && !pslverr) begin
        if (hit(paddr, `CDSP_IDX_THROTTLE)) begin
          idleSel_r <= pwdata[`CDSP_TH_IDLE];
          dozeAct_r <= pwdata[`CDSP_TH_DOZE];
          roi_r <= pwdata[`CDSP_TH_ROI];
          doe_r <= pwdata[`CDSP_TH_DOE];
          ratio_r <= pwdata[`CDSP_TH_RATIO_HI:`CDSP_TH_RATIO_LO];
        end
        if (hit(paddr, `CDSP_IDX_REGCTL)) begin
          lpSel_r <= pwdata[`CDSP_RC_LPSEL];
        end
      end
      if (irqEntry) begin
        doe_r <= dozeAct_r;
        if (roi_r) begin
          dozeAct_r <= 1'b0;
        end
      end else if (irqReturn) begin
        // value held at this moment decides, software may edit it
        dozeAct_r <= doe_r;
      end
    end
  end

  // -------------------------------------------------------------
  // sequencer next state
  // -------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    waitCnt_nxt = waitCnt_r;
    case (state_r)
      ST_RUN: begin
        // pending enabled irq with globals off: no-op
        if (sleepExec && !(enabledIrqPending &&
            !globalIrqEnable)) begin
          if (idleSel_r) begin
            state_nxt = ST_IDLE;
          end else begin
            state_nxt = ST_SLEEP;
          end
        end
      end
      ST_IDLE: begin
        if (wakeReq) begin
          state_nxt = ST_RESUME;
        end
      end
      ST_SLEEP: begin
        // a request present at entry wakes on the next edge
        if (wakeReq) begin
          waitCnt_nxt = 11'h000;
          if (crystalMode) begin
            state_nxt = ST_OST;
          end else if (lpUsed_r) begin
            state_nxt = ST_STAB;
          end else begin
            state_nxt = ST_RESUME;
          end
        end
      end
      ST_OST: begin
        waitCnt_nxt = waitCnt_r + 11'h001;
        if (waitCnt_r == OST_TOP) begin
          waitCnt_nxt = 11'h000;
          state_nxt = lpUsed_r ? ST_STAB : ST_RESUME;
        end
      end
      ST_STAB: begin
        waitCnt_nxt = waitCnt_r + 11'h001;
        if (waitCnt_r == STAB_TOP) begin
          waitCnt_nxt = 11'h000;
          state_nxt = ST_RESUME;
        end
      end
      ST_RESUME: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
        waitCnt_nxt = 11'h000;
      end
    endcase
  end

  // -------------------------------------------------------------
  // doze counter
  // -------------------------------------------------------------
  // free-running only while executing, restarts on each resume
  always @* begin
    dozeCnt_nxt = 8'h00;
    if (state_r == ST_RUN && dozeAct_r) begin
      // at or past the top: a ratio cut mid-period wraps at once
      if (dozeCnt_r >= dozeTop(ratio_r)) begin
        dozeCnt_nxt = 8'h00;
      end else begin
        dozeCnt_nxt = dozeCnt_r + 8'h01;
      end
    end
  end

  // -------------------------------------------------------------
  // sequencer registers and pulses
  // -------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      // pin, brown-out and power-on resets arrive here
      state_r <= ST_RUN;
      waitCnt_r <= 11'h000;
      dozeCnt_r <= 8'h00;
      lpUsed_r <= 1'b0;
      prefetchReq <= 1'b0;
      vectorAfterNext <= 1'b0;
      wdtClear <= 1'b0;
      powerDownFlagN <= 1'b1;
      timeoutFlagN <= 1'b1;
    end else begin
      state_r <= state_nxt;
      waitCnt_r <= waitCnt_nxt;
      dozeCnt_r <= dozeCnt_nxt;
      prefetchReq <= 1'b0;
      vectorAfterNext <= 1'b0;
      wdtClear <= 1'b0;
      if (flagsRestore) begin
        powerDownFlagN <= 1'b1;
        timeoutFlagN <= 1'b1;
      end
      if (state_r == ST_RUN && sleepExec) begin
        // next address fetched even when sleep acts as no-op
        prefetchReq <= 1'b1;
      end
      if (state_r == ST_RUN && state_nxt == ST_SLEEP) begin
        wdtClear <= 1'b1;
        powerDownFlagN <= 1'b0;
        timeoutFlagN <= 1'b1;
        lpUsed_r <= lpSel_r & ~lowVolt_r;
      end
      if (state_r == ST_SLEEP && state_nxt != ST_SLEEP) begin
        wdtClear <= 1'b1;
      end
      // a watchdog wake is no interrupt, so it never vectors
      if (state_r == ST_RESUME && globalIrqEnable &&
          enabledIrqPending) begin
        vectorAfterNext <= 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // clock gates and hold controls
  // -------------------------------------------------------------
  // registered from next state so gates change on a boundary
  always @(posedge clk) begin
    if (!rst_b) begin
      cpuClkEn <= 1'b1;
      pfmEn <= 1'b1;
      periphClkEn <= 1'b1;
      wdtRunEn <= 1'b1;
      ioHold <= 1'b0;
      regLowPower <= 1'b0;
      sleepActive <= 1'b0;
      idleActive <= 1'b0;
    end else begin
      if (state_nxt == ST_RUN) begin
        // doze: one enabled cycle per period
        cpuClkEn <= ~dozeAct_r | (dozeCnt_nxt == 8'h00);
        pfmEn <= ~dozeAct_r | (dozeCnt_nxt == 8'h00);
      end else begin
        cpuClkEn <= 1'b0;
        pfmEn <= 1'b0;
      end
      // system-clock peripherals stop in sleep and through the start-up and settle waits
      periphClkEn <= (state_nxt == ST_RUN) ||
                     (state_nxt == ST_IDLE) ||
                     (state_nxt == ST_RESUME);
      wdtRunEn <= (state_nxt != ST_SLEEP) | wdtSleepRun;
      ioHold <= (state_nxt == ST_SLEEP) || (state_nxt == ST_OST) ||
                (state_nxt == ST_STAB);
      regLowPower <= (state_nxt == ST_SLEEP) &
                     (lpSel_r & ~lowVolt_r);
      sleepActive <= (state_nxt == ST_SLEEP);
      idleActive <= (state_nxt == ST_IDLE);
    end
  end

endmodule // cdsp_power_ctrl

// ===== cdsp_power_ctrl_sva.sv
`timescale 1ns/10ps
// ------------------------------------------
// power control port checker
// ------------------------------------------
module cdsp_power_ctrl_sva (
  input wire clk,
  input wire rst_b,
  input wire sleepExec,
  input wire enabledIrqPending,
  input wire globalIrqEnable,
  input wire wdtSleepRun,
  input wire cpuClkEn,
  input wire pfmEn,
  input wire periphClkEn,
  input wire prefetchReq,
  input wire vectorAfterNext,
  input wire wdtClear,
  input wire wdtRunEn,
  input wire ioHold,
  input wire regLowPower,
  input wire sleepActive,
  input wire idleActive,
  input wire powerDownFlagN,
  input wire timeoutFlagN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // sleep only counts while the cpu clock is live (run state)
  wire runExec = sleepExec && cpuClkEn;
  a_pfm_tracks_cpu: assert property (pfmEn == cpuClkEn)
    else $error("pfm enable differs from cpu enable");
  a_sleep_gates_cpu: assert property (
    sleepActive |-> !cpuClkEn && ioHold && !periphClkEn)
    else $error("cpu clock live in sleep");
  a_idle_periph_on: assert property (
    idleActive |-> periphClkEn && !cpuClkEn && !ioHold)
    else $error("idle clocks wrong");
  a_entry_flags: assert property (
    $rose(sleepActive) |-> wdtClear ##1 !powerDownFlagN && timeoutFlagN)
    else $error("sleep entry flags wrong");
  a_noop_sleep: assert property (
    runExec && enabledIrqPending && !globalIrqEnable
    |=> !sleepActive && !wdtClear)
    else $error("pending irq did not turn sleep into no-op");
  a_prefetch_next: assert property (runExec |=> prefetchReq)
    else $error("no prefetch on sleep");
  a_sleep_wdt_run: assert property (
    sleepActive && $past(sleepActive) |-> wdtRunEn == $past(wdtSleepRun))
    else $error("watchdog run enable wrong in sleep");
  a_wake_clears_wdt: assert property ($fell(sleepActive) |-> wdtClear)
    else $error("wake without watchdog clear");
  a_vector_gie: assert property (
    vectorAfterNext |->
      $past(globalIrqEnable) && $past(enabledIrqPending) && cpuClkEn)
    else $error("vector without global enable");
  a_lowpower_held: assert property (regLowPower |-> ioHold)
    else $error("low power regulator outside sleep");
  a_resume_one: assert property (
    $fell(ioHold) |-> !cpuClkEn ##1 cpuClkEn)
    else $error("resume not one cycle");
  c_sleep: cover property ($rose(sleepActive));
  c_vector: cover property (vectorAfterNext);
  c_idle: cover property ($rose(idleActive));
endmodule // cdsp_power_ctrl_sva

// ===== cdsp_cpu_model.sv
`timescale 1ns/10ps
// ------------------------------------------
// cpu, irq and watchdog stand-in
// ------------------------------------------
module cdsp_cpu_model (
  input wire clk,
  input wire rst_b,
  input wire sleepActive,
  input wire cpuClkEn,
  input wire wdtClear,
  input wire preIrq,
  input wire clearIrq,
  input wire [11:0] wakeDelay,
  output logic enabledIrqPending,
  output int cpuCycles,
  output int wdtClears
);
  logic timedIrq; // wake source armed by the bench
  int waitCnt; // cycles spent asleep
  // only flags with their own enable set show here
  assign enabledIrqPending = preIrq | timedIrq;
  // irq fires a set time into sleep, held till acked
  always @(posedge clk) begin
    if (!rst_b || clearIrq) begin
      timedIrq <= 1'b0;
    end else if (wakeDelay != 12'h000 && waitCnt == wakeDelay) begin
      timedIrq <= 1'b1;
    end
    waitCnt <= sleepActive ? waitCnt + 1 : 0;
    // counts the bench reads back as differences
    if (!rst_b) begin
      cpuCycles <= 0;
      wdtClears <= 0;
    end else begin
      cpuCycles <= cpuCycles + cpuClkEn;
      wdtClears <= wdtClears + wdtClear;
    end
  end
endmodule // cdsp_cpu_model

// ===== cdsp_power_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "cdsp_consts.vh"
module cdsp_power_ctrl_tb_top;
  // ------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, rd;
  logic sleepExec = 0, irqEntry = 0, irqReturn = 0, globalIrqEnable = 0;
  logic wdtWake = 0, wdtSleepRun = 0, crystalMode = 0, flagsRestore = 0;
  logic lowVoltageStrap = 0, preIrq = 0, clearIrq = 0;
  logic [11:0] wakeDelay = 12'h000;
  wire [31:0] prdata;
  wire pready, pslverr, cpuClkEn, pfmEn, periphClkEn, prefetchReq, wdtClear;
  wire vectorAfterNext, wdtRunEn, ioHold, regLowPower, enabledIrqPending;
  wire sleepActive, idleActive, powerDownFlagN, timeoutFlagN;
  int cpuCycles, wdtClears, n_errors = 0, tests_run = 0, n, c0;
  localparam logic [15:0] A_RC = {`CDSP_IDX_REGCTL, 2'b00};
  localparam logic [15:0] A_TH = {`CDSP_IDX_THROTTLE, 2'b00};
  localparam logic [15:0] A_ST = {`CDSP_IDX_STATUS, 2'b00};
  // crystal start-up, regulator settle, resume, then first sample
  localparam int WAKE_LP = `CDSP_OST_PERIODS + `CDSP_REG_STAB_CYC + 2;
  cdsp_power_ctrl uut (.*);
  cdsp_cpu_model partner (.*);
  initial forever #10 clk = ~clk;
  // ------------------------------------------
  // shared tasks
  // ------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdchk(input logic [15:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rd, e);
  endtask
  task fire_sleep;
    @(posedge clk);
    sleepExec <= 1;
    @(posedge clk);
    sleepExec <= 0;
    repeat (2) @(posedge clk);
  endtask
  task pulse_irq(input logic ret);
    @(posedge clk);
    irqEntry <= !ret;
    irqReturn <= ret;
    @(posedge clk);
    irqEntry <= 0;
    irqReturn <= 0;
  endtask
  // sleep, wake by timed irq or watchdog, measure wake latency
  task sleep_wake(input logic global_irq_enable, cry, lp, run, wdw, input int lat);
    globalIrqEnable <= global_irq_enable;
    crystalMode <= cry;
    wdtSleepRun <= run;
    wakeDelay <= wdw ? 12'h000 : 12'h014;
    apb(1, A_RC, {30'h0, lp, 1'b0});
    c0 = wdtClears;
    fire_sleep;
    chk({sleepActive, ioHold, cpuClkEn, periphClkEn}, 4'hc);
    chk({powerDownFlagN, timeoutFlagN}, 2'b01);
    chk({regLowPower, wdtRunEn}, {lp, run});
    wdtWake <= wdw;
    while (enabledIrqPending !== 1'b1 && wdtWake !== 1'b1) @(posedge clk);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cpuClkEn !== 1'b1);
    chk(n, lat);
    chk(vectorAfterNext, global_irq_enable);
    chk(wdtClears - c0, 2);
    wdtWake <= 0;
    clearIrq <= 1;
    @(posedge clk);
    clearIrq <= 0;
  endtask
  task tally_and_finish;
    $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------
  // hang guard, far beyond the longest wake
  // ------------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end
  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1;
    rdchk(A_TH, 32'h0);
    rdchk(A_ST, 32'h18);
    apb(1, A_TH, 32'hff);
    rdchk(A_TH, 32'hf7);
    apb(1, A_ST, 32'h0);
    rdchk(A_ST, 32'h18);
    apb(0, 16'h0000, 32'h0);
    chk(err, 1'b1);
    // every ratio: four cpu cycles per four periods
    for (int r = 0; r < 8; r++) begin
      apb(1, A_TH, 32'h40 | r);
      repeat (2 << r) @(posedge clk);
      c0 = cpuCycles;
      repeat (8 << r) @(posedge clk);
      chk(cpuCycles - c0, 4);
    end
    // entry and return for all doze and recover settings
    for (int i = 0; i < 4; i++) begin
      apb(1, A_TH, {25'h0, i[1], i[0], 5'h0});
      pulse_irq(0);
      rdchk(A_TH, {25'h0, i[1] & ~i[0], i[0], i[1], 4'h0});
      apb(1, A_TH, {25'h0, i[1] & ~i[0], i[0], ~i[1], 4'h0});
      pulse_irq(1);
      rdchk(A_TH, {25'h0, ~i[1], i[0], ~i[1], 4'h0});
    end
    apb(1, A_TH, 32'h0);
    sleep_wake(1, 0, 0, 0, 0, 2);
    rdchk(A_ST, 32'h10);
    sleep_wake(0, 1, 1, 1, 1, WAKE_LP);
    @(posedge clk);
    flagsRestore <= 1;
    @(posedge clk);
    flagsRestore <= 0;
    rdchk(A_ST, 32'h18);
    // irq already pending with global enable off
    preIrq <= 1;
    fire_sleep;
    chk({sleepActive, powerDownFlagN, timeoutFlagN}, 3'b011);
    preIrq <= 0;
    apb(1, A_TH, 32'h80);
    fire_sleep;
    chk({idleActive, cpuClkEn, periphClkEn, sleepActive}, 4'ha);
    // watchdog wake with globals on must not vector
    globalIrqEnable <= 1;
    wdtWake <= 1;
    while (cpuClkEn !== 1'b1) @(posedge clk);
    wdtWake <= 0;
    chk(vectorAfterNext, 1'b0);
    chk(idleActive, 1'b0);
    // full reset from sleep, low-voltage strap caught
    apb(1, A_TH, 32'h0);
    fire_sleep;
    lowVoltageStrap <= 1;
    rst_b <= 0;
    repeat (10) @(posedge clk);
    chk({sleepActive, cpuClkEn, powerDownFlagN}, 3'b011);
    rst_b <= 1;
    apb(1, A_RC, 32'h2);
    rdchk(A_RC, 32'h0);
    tally_and_finish;
  end
endmodule // cdsp_power_ctrl_tb_top
bind cdsp_power_ctrl cdsp_power_ctrl_sva chk (.*);
